// *** idg_top.sv ***
// Diagnostic and observability logic of the serial bus master: baud registers,
// counter read-back select, diagnostic state register and the transfer sequencer.
// Assumes a single-cycle register port and line inputs asynchronous to clk_sys.
module idg_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input idg_pkg::idg_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  // Bus engine control
  input idg_pkg::idg_cmd_t cmd,
  input wire logic filter_en,
  // Serial line inputs
  input idg_pkg::idg_lines_t line_in,
  // Observation
  output idg_pkg::idg_xfer_state_t transfer_state_code,
  output logic stop_count_signal,
  output logic baud_tick
);

  idg_pkg::idg_top_state_t st_reg;
  idg_pkg::idg_top_state_t st_next;
  idg_pkg::idg_lines_t lines;
  logic [15:0] baud_reload_value;
  logic [15:0] baud_count;
  logic tick;
  logic nack;

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic hits(input idg_pkg::idg_bus_req_t req, input logic [11:0] ofs);
    hits = (req.addr == ofs);
  endfunction : hits

  function automatic logic is_stop(input idg_pkg::idg_xfer_state_t s);
    is_stop = (s == idg_pkg::XS_STOP_A) || (s == idg_pkg::XS_STOP_B);
  endfunction : is_stop

  function automatic idg_pkg::idg_xfer_state_t step(
    input idg_pkg::idg_xfer_state_t s,
    input logic ten_bit,
    input logic stop_req,
    input logic not_ack
  );
    step = s;
    case (s)
      idg_pkg::XS_START: begin
        if (ten_bit) begin
          step = idg_pkg::XS_F7;
        end else begin
          step = idg_pkg::XS_S7;
        end
      end
      idg_pkg::XS_D7, idg_pkg::XS_D6, idg_pkg::XS_D5, idg_pkg::XS_D4,
      idg_pkg::XS_D3, idg_pkg::XS_D2, idg_pkg::XS_D1: begin
        step = idg_pkg::idg_xfer_state_t'(s + 5'h01);
      end
      idg_pkg::XS_D0: begin
        step = idg_pkg::XS_DACK;
      end
      idg_pkg::XS_DACK: begin
        if (not_ack) begin
          step = idg_pkg::XS_DNACK;
        end else if (stop_req) begin
          step = idg_pkg::XS_STOP_A;
        end else begin
          step = idg_pkg::XS_D7;
        end
      end
      idg_pkg::XS_DNACK: begin
        step = idg_pkg::XS_STOP_A;
      end
      idg_pkg::XS_STOP_A: begin
        step = idg_pkg::XS_STOP_B;
      end
      idg_pkg::XS_STOP_B: begin
        step = idg_pkg::XS_IDLE;
      end
      idg_pkg::XS_F7, idg_pkg::XS_F6, idg_pkg::XS_F5, idg_pkg::XS_F4,
      idg_pkg::XS_F3, idg_pkg::XS_F2, idg_pkg::XS_F1: begin
        step = idg_pkg::idg_xfer_state_t'(s + 5'h01);
      end
      idg_pkg::XS_F0: begin
        step = idg_pkg::XS_FACK;
      end
      idg_pkg::XS_FACK: begin
        if (not_ack) begin
          step = idg_pkg::XS_STOP_A;
        end else begin
          step = idg_pkg::XS_S7;
        end
      end
      idg_pkg::XS_S7, idg_pkg::XS_S6, idg_pkg::XS_S5, idg_pkg::XS_S4,
      idg_pkg::XS_S3, idg_pkg::XS_S2: begin
        step = idg_pkg::idg_xfer_state_t'(s + 5'h01);
      end
      idg_pkg::XS_S1: begin
        step = idg_pkg::XS_ALSB;
      end
      idg_pkg::XS_ALSB: begin
        step = idg_pkg::XS_AACK;
      end
      idg_pkg::XS_AACK: begin
        if (not_ack) begin
          step = idg_pkg::XS_STOP_A;
        end else begin
          step = idg_pkg::XS_D7;
        end
      end
      default: begin
        step = s;
      end
    endcase
  endfunction : step

  // ****************************************
  // Line synchroniser and baud counter
  // ****************************************
  idg_line_sync idg_line_sync_i (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .filter_en(filter_en),
    .line_in(line_in),
    .line_out(lines)
  );

  assign baud_reload_value = {st_reg.reload_high_field, st_reg.reload_low_field};

  idg_baud_counter idg_baud_counter_i (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .baud_reload_value(baud_reload_value),
    .count(baud_count),
    .tick(tick)
  );

  assign nack = lines.data_line_level;

  // ****************************************
  // Registers and sequencer
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.rdata = idg_pkg::READ_IDLE;
    if (bus_req.wr) begin
      if (hits(bus_req, idg_pkg::OFS_BAUD_HIGH)) begin
        st_next.reload_high_field = bus_req.wdata;
      end else if (hits(bus_req, idg_pkg::OFS_BAUD_LOW)) begin
        st_next.reload_low_field = bus_req.wdata;
      end else if (hits(bus_req, idg_pkg::OFS_COUNTER_READBACK_SELECT_CTRL)) begin
        st_next.counter_readback_select = bus_req.wdata[idg_pkg::CTRL_SEL_BIT];
      end
    end
    if (bus_req.rd) begin
      if (hits(bus_req, idg_pkg::OFS_BAUD_HIGH)) begin
        st_next.rdata = st_reg.counter_readback_select ? baud_count[15:8]
                                                       : st_reg.reload_high_field;
      end else if (hits(bus_req, idg_pkg::OFS_BAUD_LOW)) begin
        st_next.rdata = st_reg.counter_readback_select ? baud_count[7:0]
                                                       : st_reg.reload_low_field;
      end else if (hits(bus_req, idg_pkg::OFS_COUNTER_READBACK_SELECT_STATE)) begin
        st_next.rdata[idg_pkg::STATE_SCL_BIT] = lines.clock_line_level;
        st_next.rdata[idg_pkg::STATE_SDA_BIT] = lines.data_line_level;
        st_next.rdata[idg_pkg::STATE_STOP_BIT] = st_reg.stop_count_signal;
        st_next.rdata[idg_pkg::STATE_CODE_LSB +: 5] = st_reg.transfer_state_code;
      end else if (hits(bus_req, idg_pkg::OFS_COUNTER_READBACK_SELECT_CTRL)) begin
        st_next.rdata[idg_pkg::CTRL_SEL_BIT] = st_reg.counter_readback_select;
      end
    end
    if (st_reg.transfer_state_code == idg_pkg::XS_IDLE) begin
      if (cmd.start) begin
        st_next.transfer_state_code = idg_pkg::XS_START;
      end
    end else if (tick) begin
      st_next.transfer_state_code = step(st_reg.transfer_state_code, cmd.ten_bit, cmd.stop, nack);
    end
    st_next.stop_count_signal = is_stop(st_next.transfer_state_code);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '{reload_high_field: idg_pkg::BAUD_HIGH_RST,
                  reload_low_field: idg_pkg::BAUD_LOW_RST,
                  counter_readback_select: idg_pkg::COUNTER_READBACK_SELECT_CTRL_RST[idg_pkg::CTRL_SEL_BIT],
                  rdata: idg_pkg::READ_IDLE,
                  transfer_state_code: idg_pkg::XS_IDLE,
                  stop_count_signal: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign bus_rdata = st_reg.rdata;
  assign transfer_state_code = st_reg.transfer_state_code;
  assign stop_count_signal = st_reg.stop_count_signal;
  assign baud_tick = tick;

  // ****************************************
  // Assertions and covers
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  low_normal_read_a: assert property (
    bus_req.rd && hits(bus_req, idg_pkg::OFS_BAUD_LOW) && !st_reg.counter_readback_select
    |=> bus_rdata == $past(st_reg.reload_low_field))
    else $error("low byte read did not return reload value");

  low_counter_readback_select_read_a: assert property (
    bus_req.rd && hits(bus_req, idg_pkg::OFS_BAUD_LOW) && st_reg.counter_readback_select
    |=> bus_rdata == $past(baud_count[7:0]))
    else $error("low byte read did not return counter value");

  high_byte_read_a: assert property (
    bus_req.rd && hits(bus_req, idg_pkg::OFS_BAUD_HIGH)
    |=> bus_rdata == ($past(st_reg.counter_readback_select) ? $past(baud_count[15:8])
                                                            : $past(st_reg.reload_high_field)))
    else $error("high byte read returned wrong source");

  ctrl_reserved_a: assert property (
    bus_req.rd && hits(bus_req, idg_pkg::OFS_COUNTER_READBACK_SELECT_CTRL)
    |=> bus_rdata[7:1] == 7'h00 && bus_rdata[0] == $past(st_reg.counter_readback_select))
    else $error("control register read back wrong");

  state_read_a: assert property (
    bus_req.rd && hits(bus_req, idg_pkg::OFS_COUNTER_READBACK_SELECT_STATE)
    |=> bus_rdata == {$past(lines.clock_line_level), $past(lines.data_line_level),
                      $past(stop_count_signal), $past(transfer_state_code)})
    else $error("state register read does not match internal state");

  state_ro_a: assert property (
    bus_req.wr && hits(bus_req, idg_pkg::OFS_COUNTER_READBACK_SELECT_STATE)
    |=> $stable(baud_reload_value) && $stable(st_reg.counter_readback_select))
    else $error("write to state register changed a register");

  start_entry_a: assert property (
    transfer_state_code == idg_pkg::XS_IDLE && cmd.start |=> transfer_state_code == idg_pkg::XS_START)
    else $error("start request did not enter start state");

  ten_bit_path_a: assert property (
    transfer_state_code == idg_pkg::XS_START && tick && cmd.ten_bit
    |=> transfer_state_code == idg_pkg::XS_F7)
    else $error("ten-bit start did not enter first address byte");

  first_ack_a: assert property (
    transfer_state_code == idg_pkg::XS_F0 && tick |=> transfer_state_code == idg_pkg::XS_FACK)
    else $error("first address byte not acknowledged after bit 0");

  addr_tail_a: assert property (
    transfer_state_code == idg_pkg::XS_S1 && tick |=> transfer_state_code == idg_pkg::XS_ALSB)
    else $error("address bit 1 not followed by last address bit");

  addr_ack_a: assert property (
    transfer_state_code == idg_pkg::XS_ALSB && tick |=> transfer_state_code == idg_pkg::XS_AACK)
    else $error("last address bit not followed by address acknowledge");

  data_ack_a: assert property (
    transfer_state_code == idg_pkg::XS_D0 && tick |=> transfer_state_code == idg_pkg::XS_DACK)
    else $error("data bit 0 not followed by data acknowledge");

  nack_only_a: assert property (
    transfer_state_code == idg_pkg::XS_DACK && tick && !nack
    |=> transfer_state_code != idg_pkg::XS_DNACK)
    else $error("second acknowledge half entered without not-acknowledge");

  stop_pair_a: assert property (
    transfer_state_code == idg_pkg::XS_STOP_A && tick
    |=> transfer_state_code == idg_pkg::XS_STOP_B && stop_count_signal)
    else $error("stop first part not followed by second part");

  stop_flag_a: assert property (
    stop_count_signal == is_stop(transfer_state_code))
    else $error("stop count signal out of step with state");

  low_write_a: assert property (
    bus_req.wr && hits(bus_req, idg_pkg::OFS_BAUD_LOW)
    |=> st_reg.reload_low_field == $past(bus_req.wdata))
    else $error("low byte write did not land");

  high_write_a: assert property (
    bus_req.wr && hits(bus_req, idg_pkg::OFS_BAUD_HIGH)
    |=> st_reg.reload_high_field == $past(bus_req.wdata))
    else $error("high byte write did not land");

  select_write_a: assert property (
    bus_req.wr && hits(bus_req, idg_pkg::OFS_COUNTER_READBACK_SELECT_CTRL)
    |=> st_reg.counter_readback_select == $past(bus_req.wdata[idg_pkg::CTRL_SEL_BIT]))
    else $error("select bit write did not land");

  seven_bit_path_a: assert property (
    transfer_state_code == idg_pkg::XS_START && tick && !cmd.ten_bit
    |=> transfer_state_code == idg_pkg::XS_S7)
    else $error("seven-bit start did not enter address bit 7");

  data_step_a: assert property (
    transfer_state_code inside {[idg_pkg::XS_D7:idg_pkg::XS_D1]} && tick
    |=> transfer_state_code == 5'($past(transfer_state_code) + 5'h01))
    else $error("data bit states not consecutive");

  addr_step_a: assert property (
    transfer_state_code inside {[idg_pkg::XS_S7:idg_pkg::XS_S2]} && tick
    |=> transfer_state_code == 5'($past(transfer_state_code) + 5'h01))
    else $error("address bit states not consecutive");

  nack_stop_a: assert property (
    transfer_state_code == idg_pkg::XS_DNACK && tick
    |=> transfer_state_code == idg_pkg::XS_STOP_A)
    else $error("second acknowledge half not followed by stop");

  ack_stop_a: assert property (
    transfer_state_code == idg_pkg::XS_DACK && tick && !nack && cmd.stop
    |=> transfer_state_code == idg_pkg::XS_STOP_A)
    else $error("stop request after acknowledge did not enter stop");

  state_hold_a: assert property (
    transfer_state_code != idg_pkg::XS_IDLE && !tick |=> $stable(transfer_state_code))
    else $error("state code moved without a baud tick");

  counter_readback_select_read_c: cover property (
    st_reg.counter_readback_select && bus_req.rd && hits(bus_req, idg_pkg::OFS_BAUD_HIGH));
  ten_bit_c: cover property (transfer_state_code == idg_pkg::XS_FACK);
  nack_c: cover property (transfer_state_code == idg_pkg::XS_DNACK);
  stop_c: cover property (transfer_state_code == idg_pkg::XS_STOP_B ##1
                          transfer_state_code == idg_pkg::XS_IDLE);
  seven_bit_c: cover property (transfer_state_code == idg_pkg::XS_AACK);

endmodule : idg_top

// *** idg_pkg.sv ***
// Shared constants, types and carriers for the bus diagnostic block.
// Assumes an 8-bit register port with 12-bit addresses and one system clock.
package idg_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_BAUD_HIGH = 12'hF53;
  localparam logic [11:0] OFS_BAUD_LOW = 12'hF54;
  localparam logic [11:0] OFS_COUNTER_READBACK_SELECT_STATE = 12'hF55;
  localparam logic [11:0] OFS_COUNTER_READBACK_SELECT_CTRL = 12'hF56;

  // ****************************************
  // Reset values and field positions
  // ****************************************
  localparam logic [7:0] BAUD_HIGH_RST = 8'hFF;
  localparam logic [7:0] BAUD_LOW_RST = 8'hFF;
  localparam logic [7:0] COUNTER_READBACK_SELECT_CTRL_RST = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'hFFFF;
  localparam logic [15:0] COUNT_LAST = 16'h0001;
  localparam logic LINE_RST = 1'b1;
  localparam int CTRL_SEL_BIT = 0;
  localparam int STATE_SCL_BIT = 7;
  localparam int STATE_SDA_BIT = 6;
  localparam int STATE_STOP_BIT = 5;
  localparam int STATE_CODE_LSB = 0;

  // ****************************************
  // Transfer state codes
  // ****************************************
  typedef enum logic [4:0] {
    XS_IDLE = 5'b0_0000, XS_START = 5'b0_0001, XS_D7 = 5'b0_0010, XS_D6 = 5'b0_0011,
    XS_D5 = 5'b0_0100, XS_D4 = 5'b0_0101, XS_D3 = 5'b0_0110, XS_D2 = 5'b0_0111,
    XS_D1 = 5'b0_1000, XS_D0 = 5'b0_1001, XS_DACK = 5'b0_1010, XS_DNACK = 5'b0_1011,
    XS_STOP_A = 5'b0_1100, XS_STOP_B = 5'b0_1101, XS_AACK = 5'b0_1110, XS_ALSB = 5'b0_1111,
    XS_F7 = 5'b1_0000, XS_F6 = 5'b1_0001, XS_F5 = 5'b1_0010, XS_F4 = 5'b1_0011,
    XS_F3 = 5'b1_0100, XS_F2 = 5'b1_0101, XS_F1 = 5'b1_0110, XS_F0 = 5'b1_0111,
    XS_FACK = 5'b1_1000, XS_S7 = 5'b1_1001, XS_S6 = 5'b1_1010, XS_S5 = 5'b1_1011,
    XS_S4 = 5'b1_1100, XS_S3 = 5'b1_1101, XS_S2 = 5'b1_1110, XS_S1 = 5'b1_1111
  } idg_xfer_state_t;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } idg_bus_req_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic ten_bit;
  } idg_cmd_t;

  typedef struct packed {
    logic clock_line_level;
    logic data_line_level;
  } idg_lines_t;

  // ****************************************
  // Module state records
  // ****************************************
  typedef struct packed {
    logic [7:0] reload_high_field;
    logic [7:0] reload_low_field;
    logic counter_readback_select;
    logic [7:0] rdata;
    idg_xfer_state_t transfer_state_code;
    logic stop_count_signal;
  } idg_top_state_t;

  typedef struct packed {
    logic [15:0] count;
  } idg_brg_state_t;

  typedef struct packed {
    logic [1:0] stage1;
    logic [1:0] stage2;
    logic [1:0] hist;
    logic [1:0] level;
  } idg_sync_state_t;

endpackage : idg_pkg

// *** idg_line_sync.sv ***
// Two-flop synchroniser and optional glitch filter for the clock and data lines.
// Assumes line inputs idle high; filter enable is a quasi-static control level.
module idg_line_sync (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Control
  input wire logic filter_en,
  // Lines
  input idg_pkg::idg_lines_t line_in,
  output idg_pkg::idg_lines_t line_out
);

  idg_pkg::idg_sync_state_t st_reg;
  idg_pkg::idg_sync_state_t st_next;
  logic [1:0] raw;

  assign raw = {line_in.clock_line_level, line_in.data_line_level};

  // ****************************************
  // Per-line sync and filter
  // ****************************************
  always_comb begin
    st_next = st_reg;
    st_next.stage1 = raw;
    st_next.stage2 = st_reg.stage1;
    st_next.hist = st_reg.stage2;
    for (int i = 0; i < 2; i++) begin
      if (!filter_en || (st_reg.stage2[i] == st_reg.hist[i])) begin
        st_next.level[i] = st_reg.stage2[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg <= {8{idg_pkg::LINE_RST}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign line_out.clock_line_level = st_reg.level[1];
  assign line_out.data_line_level = st_reg.level[0];

  sync_pass_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !filter_en |=> st_reg.level == $past(st_reg.stage2))
    else $error("unfiltered line level does not follow synchroniser");

endmodule : idg_line_sync

// *** idg_baud_counter.sv ***
// Down counter of the baud-rate generator, reloaded from the 16-bit reload value.
// Assumes the reload value is stable software state.
module idg_baud_counter (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Reload and count
  input wire logic [15:0] baud_reload_value,
  output logic [15:0] count,
  output logic tick
);

  idg_pkg::idg_brg_state_t st_reg;
  idg_pkg::idg_brg_state_t st_next;

  // ****************************************
  // Count down to one, then reload
  // ****************************************
  assign tick = (st_reg.count <= idg_pkg::COUNT_LAST);

  always_comb begin
    st_next = st_reg;
    if (tick) begin
      st_next.count = baud_reload_value;
    end else begin
      st_next.count = st_reg.count - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '{count: idg_pkg::COUNT_RST};
    end else begin
      st_reg <= st_next;
    end
  end

  assign count = st_reg.count;

  count_reload_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    tick |=> count == $past(baud_reload_value))
    else $error("counter did not reload after reaching one");

endmodule : idg_baud_counter

// *** idg_top_bench.sv ***
// Self-checking bench for the serial bus diagnostic block.
// Assumes idg_pkg, the synchroniser, the baud counter and idg_top are compiled first.
module idg_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Signals
  // ****************************************
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  idg_pkg::idg_bus_req_t bus_req = '0;
  idg_pkg::idg_cmd_t cmd = '0;
  idg_pkg::idg_lines_t line_in = 2'b11;
  logic filter_en = 1'b0;
  logic [7:0] bus_rdata;
  idg_pkg::idg_xfer_state_t transfer_state_code;
  logic stop_count_signal;
  logic baud_tick;
  int error_cnt = 0;
  int checks_done = 0;
  logic mon_en = 1'b0;
  logic [4:0] exp_code = 5'h00;
  logic p_tick = 1'b0;
  logic p_start = 1'b0;
  logic p_ten = 1'b0;
  logic p_stop = 1'b0;
  logic p_nack = 1'b0;
  logic [7:0] v [4];

  always #10 clk_sys = ~clk_sys;

  idg_top idg_top_i (
    .clk_sys(clk_sys), .resetn(resetn), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .cmd(cmd), .filter_en(filter_en), .line_in(line_in),
    .transfer_state_code(transfer_state_code), .stop_count_signal(stop_count_signal),
    .baud_tick(baud_tick)
  );

  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic finish_test();
    $display("Checks made %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  function automatic logic [4:0] nxt(input logic [4:0] s, input logic ten, input logic stp,
                                     input logic nk);
    case (s)
      5'h00: nxt = 5'h00;
      5'h01: nxt = ten ? 5'h10 : 5'h19;
      5'h18: nxt = nk ? 5'h0C : 5'h19;
      5'h1F: nxt = 5'h0F;
      5'h0F: nxt = 5'h0E;
      5'h0E: nxt = nk ? 5'h0C : 5'h02;
      5'h0A: nxt = nk ? 5'h0B : (stp ? 5'h0C : 5'h02);
      5'h0B: nxt = 5'h0C;
      5'h0D: nxt = 5'h00;
      default: nxt = s + 5'h01;
    endcase
  endfunction : nxt

  // ****************************************
  // State sequence monitor
  // ****************************************
  always @(negedge clk_sys) begin
    logic sc;
    if (mon_en) begin
      if (exp_code == 5'h00) exp_code = p_start ? 5'h01 : 5'h00;
      else if (p_tick) exp_code = nxt(exp_code, p_ten, p_stop, p_nack);
      sc = (exp_code == 5'h0C) || (exp_code == 5'h0D);
      chk("state code", {3'h0, transfer_state_code}, {3'h0, exp_code});
      chk("stop count", {7'h00, stop_count_signal}, {7'h00, sc});
    end
    p_tick = baud_tick;
    p_start = cmd.start;
    p_ten = cmd.ten_bit;
    p_stop = cmd.stop;
    p_nack = line_in.data_line_level;
  end

  // ****************************************
  // Register port tasks
  // ****************************************
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    @(negedge clk_sys);
    d = bus_rdata;
  endtask : rd

  task automatic rd_state(input string nm);
    logic [7:0] e;
    @(posedge clk_sys);
    bus_req.addr <= idg_pkg::OFS_COUNTER_READBACK_SELECT_STATE;
    bus_req.rd <= 1'b1;
    @(negedge clk_sys);
    #1;
    e = {line_in.clock_line_level, line_in.data_line_level,
         (exp_code == 5'h0C) || (exp_code == 5'h0D), exp_code};
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    @(negedge clk_sys);
    chk(nm, bus_rdata, e);
  endtask : rd_state

  task automatic burst(input logic [7:0] rl);
    @(posedge clk_sys);
    bus_req.addr <= idg_pkg::OFS_BAUD_LOW;
    bus_req.rd <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      if (i == 3) bus_req.rd <= 1'b0;
      @(negedge clk_sys);
      v[i] = bus_rdata;
    end
    for (int i = 1; i < 4; i++)
      chk("counter low", v[i], (v[i-1] == 8'h01 && rl != 8'h00) ? rl : v[i-1] - 8'h01);
  endtask : burst

  // ****************************************
  // Transfer tasks
  // ****************************************
  task automatic wait_code(input logic [4:0] c);
    int n;
    n = 0;
    while (transfer_state_code !== c && n < 600) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 600) begin
      error_cnt++;
      $display("CHECK FAILED state wait expected %h seen %h", c, transfer_state_code);
    end
  endtask : wait_code

  task automatic xfer(input logic ten, input logic stp, input int nk);
    @(posedge clk_sys);
    line_in <= {1'($urandom), nk == 1};
    filter_en <= 1'($urandom);
    cmd <= '{start: 1'b0, stop: stp, ten_bit: ten};
    repeat (6) @(posedge clk_sys);
    rd_state("state idle");
    @(posedge clk_sys);
    cmd.start <= 1'b1;
    wait_code(5'h01);
    @(posedge clk_sys);
    cmd.start <= 1'b0;
    rd_state("state busy");
    if (nk == 2) begin
      wait_code(5'h02);
      @(posedge clk_sys);
      line_in.data_line_level <= 1'b1;
    end
    if (!stp) begin
      wait_code(5'h0A);
      wait_code(5'h02);
      @(posedge clk_sys);
      cmd.stop <= 1'b1;
    end
    wait_code(5'h00);
    $display("Test transfer ten %0d stop %0d nack %0d done", ten, stp, nk);
  endtask : xfer

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    logic [7:0] rv;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [11:0] ua;
    int n;
    void'($urandom(42433));
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    mon_en = 1'b1;
    wr(idg_pkg::OFS_COUNTER_READBACK_SELECT_CTRL, 8'h01);
    rd(idg_pkg::OFS_BAUD_HIGH, rv);
    chk("counter high", rv, 8'hFF);
    burst(8'h00);
    wr(idg_pkg::OFS_COUNTER_READBACK_SELECT_CTRL, 8'hFE);
    rd(idg_pkg::OFS_COUNTER_READBACK_SELECT_CTRL, rv);
    chk("control reserved", rv, 8'h00);
    rd(idg_pkg::OFS_BAUD_HIGH, rv);
    chk("reload high reset", rv, 8'hFF);
    rd(idg_pkg::OFS_BAUD_LOW, rv);
    chk("reload low reset", rv, 8'hFF);
    rd_state("state reset");
    $display("Test reset and counter read-back done");
    for (int i = 0; i < 6; i++) begin
      hi = 8'($urandom);
      lo = 8'($urandom);
      wr(idg_pkg::OFS_BAUD_HIGH, hi);
      wr(idg_pkg::OFS_BAUD_LOW, lo);
      rd(idg_pkg::OFS_BAUD_HIGH, rv);
      chk("reload high", rv, hi);
      rd(idg_pkg::OFS_BAUD_LOW, rv);
      chk("reload low", rv, lo);
      wr(idg_pkg::OFS_COUNTER_READBACK_SELECT_STATE, 8'($urandom));
      rd_state("state after write");
      ua = 12'($urandom);
      if (ua inside {[12'hF53:12'hF56]}) ua = 12'h000;
      wr(ua, 8'hFF);
      rd(ua, rv);
      chk("unmapped read", rv, idg_pkg::READ_IDLE);
    end
    $display("Test random register access done");
    wr(idg_pkg::OFS_BAUD_HIGH, 8'h00);
    wr(idg_pkg::OFS_BAUD_LOW, 8'h04);
    n = 0;
    while (baud_tick !== 1'b1 && n < 70000) begin
      @(negedge clk_sys);
      n++;
    end
    chk("first tick", {7'h00, baud_tick}, 8'h01);
    wr(idg_pkg::OFS_COUNTER_READBACK_SELECT_CTRL, 8'h01);
    burst(8'h04);
    rd(idg_pkg::OFS_BAUD_HIGH, rv);
    chk("counter high run", rv, 8'h00);
    wr(idg_pkg::OFS_COUNTER_READBACK_SELECT_CTRL, 8'h00);
    rd(idg_pkg::OFS_BAUD_LOW, rv);
    chk("reload low normal", rv, 8'h04);
    $display("Test counter select done");
    xfer(1'b0, 1'b1, 0);
    xfer(1'b1, 1'b1, 0);
    xfer(1'b0, 1'b0, 0);
    xfer(1'b1, 1'b0, 0);
    xfer(1'b0, 1'b1, 1);
    xfer(1'b1, 1'b1, 1);
    xfer(1'b0, 1'b1, 2);
    wr(idg_pkg::OFS_COUNTER_READBACK_SELECT_CTRL, 8'h01);
    rd(idg_pkg::OFS_COUNTER_READBACK_SELECT_CTRL, rv);
    chk("control select", rv, 8'h01);
    @(posedge clk_sys);
    cmd.start <= 1'b1;
    wait_code(5'h1A);
    @(posedge clk_sys);
    cmd.start <= 1'b0;
    line_in <= 2'b11;
    resetn <= 1'b0;
    mon_en = 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    exp_code = 5'h00;
    mon_en = 1'b1;
    rd_state("state mid reset");
    rd(idg_pkg::OFS_COUNTER_READBACK_SELECT_CTRL, rv);
    chk("control mid reset", rv, 8'h00);
    rd(idg_pkg::OFS_BAUD_HIGH, rv);
    chk("reload high mid reset", rv, 8'hFF);
    rd(idg_pkg::OFS_BAUD_LOW, rv);
    chk("reload low mid reset", rv, 8'hFF);
    $display("Test mid-run reset done");
    finish_test();
  end

  initial begin
    repeat (100000) @(posedge clk_sys);
    error_cnt++;
    $display("CHECK FAILED watchdog expected end of tests seen timeout");
    finish_test();
  end

endmodule : idg_top_bench
